// [core/fixed_counter_defines.vh]
// register addresses, field positions and reset values of the fixed event counters
`ifndef FIXED_COUNTER_DEFINES_VH
`define FIXED_COUNTER_DEFINES_VH

`define NUM_FIXED          4
`define NUM_GP             2
`define NUM_FLAGS          8

`define ADDR_FIX_CTR0      32'h0000_0309
`define ADDR_FIX_CTR1      32'h0000_030a
`define ADDR_FIX_CTR2      32'h0000_030b
`define ADDR_FIX_CTR3      32'h0000_030c
`define ADDR_FIX_CTRL      32'h0000_038d
`define ADDR_GLB_EN        32'h0000_03a0
`define ADDR_GLB_STAT      32'h0000_03a1
`define ADDR_GLB_CLR       32'h0000_03a2

`define CTL_GROUP_W        4
`define CTL_EN_RING0       0
`define CTL_EN_RINGN       1
`define CTL_PMI            3
`define CTL_USED_W         16
`define CTL_RESET          16'h0000

`define ST_GP_LSB          0
`define ST_FIX_LSB         32
`define ST_BUF_OVF         62
`define ST_COND_CHG        63

`define FLAG_FIX_LSB       2
`define FLAG_BUF_OVF       6
`define FLAG_COND_CHG      7

`define GLB_EN_MASK        64'h0000_000f_0000_0003
`define GLB_CLR_MASK       64'hc000_000f_0000_0003
`define CTL_MASK           64'h0000_0000_0000_ffff
`define ZERO64             64'h0000_0000_0000_0000

`endif

// [core/fixed_counter_slice.v]
// one fixed-function counter with load, gated increment and wrap detection
`timescale 1ns/1ps
module fixed_counter_slice #(
    parameter CTR_WIDTH = 48,
    parameter INC_WIDTH = 8
) (
    input  wire                 ref_clk,
    input  wire                 resetn,
    input  wire                 count_en,
    input  wire [INC_WIDTH-1:0] inc,
    input  wire                 load_en,
    input  wire [CTR_WIDTH-1:0] load_value,
    output reg  [CTR_WIDTH-1:0] value_reg,
    output reg                  overflow_reg
);
    wire [CTR_WIDTH:0] sum;

    assign sum = {1'b0, value_reg} + {{(CTR_WIDTH + 1 - INC_WIDTH){1'b0}}, inc};

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            value_reg    <= {CTR_WIDTH{1'b0}};
            overflow_reg <= 1'b0;
        end else if (load_en) begin
            // a software load takes the cycle; no event is counted in it
            value_reg    <= load_value;
            overflow_reg <= 1'b0;
        end else begin
            if (count_en)
                value_reg <= sum[CTR_WIDTH-1:0];
            overflow_reg <= count_en & sum[CTR_WIDTH]; // [R19]
        end
    end
endmodule

// [core/status_flag.v]
// sticky status bit: hardware set wins over any clear in the same cycle
`timescale 1ns/1ps
module status_flag (
    input  wire ref_clk,
    input  wire resetn,
    input  wire set,
    input  wire hw_clear,
    input  wire sw_clear,
    output reg  flag_reg
);
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            flag_reg <= 1'b0;
        else
            flag_reg <= set | (flag_reg & ~hw_clear & ~sw_clear);
    end
endmodule

// [core/fixed_event_counter_control.v]
// fixed event counters with privilege control, global enable, status and clear
//
// What this block does
// R1: control register holds one 4-bit group per fixed counter, each for its own counter
// R2: group bit 0 enables counting of events occurring at ring zero
// R3: group bit 1 enables counting of events occurring above ring zero
// R4: both enable bits zero stops the counter; both one counts at any level
// R5: group bit 3 makes an overflow of that counter raise the interrupt
// R6: global enable bit ANDed with privilege enables decides whether a counter counts
// R7: counter zero counts retired instructions, also inside interrupts and handlers
// R8: counter one counts core cycles while the logical processor is not halted
// R9: with one logical processor, core-scope unhalted cycles equal thread cycles
// R10: counter two counts timestamp-rate ticks when not halted nor thermally stopped
// R11: halt or monitor-wait execution enters halt and suspends unhalted counters
// R12: counter three adds the narrowest pipeline width per available unhalted slot cycle
// R13: status bits 0, 1 and 32 upward flag overflow of the associated counter
// R14: status bit 62 reports debug-store buffer overflow
// R15: status bit 63 reports a change of monitoring hardware state
// R16: precise-sampling overflow interrupts; record store clears flag, sets buffer bit
// R17: one write to the clear register clears any combination of flags
// R18: software should clear flags when reprogramming, reloading or disabling counters
// R19: a counter wrapping past its maximum to zero sets its overflow flag
// R20: counter width reported; bits above it are reserved and must be zero
// R21: the fixed counter control register sits at address 38d
`timescale 1ns/1ps
`include "fixed_counter_defines.vh"
module fixed_event_counter_control #(
    parameter CTR_WIDTH  = 48,
    parameter PIPE_WIDTH = 4
) (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        msr_wr_en,
    input  wire        msr_rd_en,
    input  wire [31:0] msr_addr,
    input  wire [63:0] msr_wdata,
    output reg  [63:0] msr_rdata_reg,
    output reg         msr_done_reg,
    output reg         msr_fault_reg,
    input  wire        cpl_is_ring0,
    input  wire        instr_retired,
    input  wire        halt_instruction_exec,
    input  wire        monitor_wait_exec,
    input  wire        halt_wake,
    input  wire        thermal_stop_clock,
    input  wire        timestamp_tick,
    input  wire        slot_available,
    input  wire [1:0]  gp_overflow,
    input  wire [3:0]  precise_sampling_enable,
    input  wire [3:0]  precise_record_done,
    input  wire        condition_change_event,
    output reg         monitor_overflow_interrupt_reg,
    output reg  [1:0]  gp_count_enable_reg,
    output reg  [7:0]  fixed_counter_width_reg,
    output reg         halted_reg
);
    localparam INC_WIDTH = 8;
    localparam [7:0] WIDTH_CODE = CTR_WIDTH[7:0];
    localparam [INC_WIDTH-1:0] SLOT_INC = PIPE_WIDTH[INC_WIDTH-1:0];
    localparam [INC_WIDTH-1:0] ONE_INC = 8'h01;
    localparam [INC_WIDTH-1:0] NO_INC = 8'h00;

    // privilege and global gating of one counter
    function count_gate;
        input [3:0] group;
        input       glb_en;
        input       ring0;
        begin
            count_gate = glb_en &                                // [R6]
                         ((group[`CTL_EN_RING0] & ring0) |       // [R2]
                          (group[`CTL_EN_RINGN] & ~ring0));      // [R3] [R4]
        end
    endfunction

    // reserved bits above the counter width must be written as zero
    function reserved_clear;
        input [63:0] data;
        input [63:0] mask;
        begin
            reserved_clear = ~|(data & ~mask);
        end
    endfunction

    reg  [`CTL_USED_W-1:0] fixed_counter_control_reg;
    reg  [1:0]             glb_gp_en_reg;
    reg  [3:0]             glb_fix_en_reg;
    reg  [63:0]            msr_rdata_next;
    reg                    msr_fault_next;
    reg  [3:0]             count_en;
    reg  [INC_WIDTH*4-1:0] inc_vec;
    reg  [3:0]             load_en;
    reg                    wr_ctl;
    reg                    wr_glb;
    reg                    wr_clr;
    integer                i;

    wire [63:0]            ctr_mask;
    wire [CTR_WIDTH-1:0]   ctr_value [0:3];
    wire [3:0]             ctr_ovf;
    wire [`NUM_FLAGS-1:0]  flag_set;
    wire [`NUM_FLAGS-1:0]  flag_hw_clr;
    wire [`NUM_FLAGS-1:0]  flag_sw_clr;
    wire [`NUM_FLAGS-1:0]  flags;
    wire [63:0]            status_word;
    wire                   halt_enter;
    wire                   wr_ok;
    wire                   access;
    wire                   pmi_next;
    wire                   unhalted;

    // a full 64-bit shift gives zero, so the mask then wraps to all ones
    assign ctr_mask = (64'h0000_0000_0000_0001 << CTR_WIDTH) - 64'h0000_0000_0000_0001;
    assign access   = msr_wr_en | msr_rd_en;

    // halt tracking; a halt entry in the same cycle as a wake keeps the core halted
    assign halt_enter = halt_instruction_exec | monitor_wait_exec;           // [R11]
    assign unhalted   = ~halted_reg;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            halted_reg <= 1'b0;
        else
            halted_reg <= halt_enter | (halted_reg & ~halt_wake);           // [R11]
    end

    // per-counter event increment and gating
    always @* begin
        inc_vec = {(INC_WIDTH*4){1'b0}};
        inc_vec[INC_WIDTH*0 +: INC_WIDTH] = instr_retired ? ONE_INC : NO_INC;   // [R7]
        // one logical processor per core: thread and core scope are the same count
        inc_vec[INC_WIDTH*1 +: INC_WIDTH] = unhalted ? ONE_INC : NO_INC;        // [R8] [R9]
        inc_vec[INC_WIDTH*2 +: INC_WIDTH] =
            (timestamp_tick & unhalted & ~thermal_stop_clock) ? ONE_INC : NO_INC; // [R10]
        inc_vec[INC_WIDTH*3 +: INC_WIDTH] =
            (slot_available & unhalted) ? SLOT_INC : NO_INC;                    // [R12]
        for (i = 0; i < `NUM_FIXED; i = i + 1)
            count_en[i] = count_gate(
                fixed_counter_control_reg[`CTL_GROUP_W*i +: `CTL_GROUP_W],      // [R1]
                glb_fix_en_reg[i], cpl_is_ring0);
    end

    // register write decode
    always @* begin
        load_en        = 4'h0;
        wr_ctl         = 1'b0;
        wr_glb         = 1'b0;
        wr_clr         = 1'b0;
        msr_fault_next = 1'b0;
        if (msr_wr_en) begin
            case (msr_addr)
                `ADDR_FIX_CTR0, `ADDR_FIX_CTR1, `ADDR_FIX_CTR2, `ADDR_FIX_CTR3: begin
                    if (reserved_clear(msr_wdata, ctr_mask))                     // [R20]
                        load_en[msr_addr[1:0] - 2'h1] = 1'b1;
                    else
                        msr_fault_next = 1'b1;
                end
                `ADDR_FIX_CTRL: begin                                            // [R21]
                    wr_ctl         = reserved_clear(msr_wdata, `CTL_MASK);
                    msr_fault_next = ~wr_ctl;
                end
                `ADDR_GLB_EN: begin
                    wr_glb         = reserved_clear(msr_wdata, `GLB_EN_MASK);
                    msr_fault_next = ~wr_glb;
                end
                `ADDR_GLB_CLR: begin
                    wr_clr         = reserved_clear(msr_wdata, `GLB_CLR_MASK);
                    msr_fault_next = ~wr_clr;
                end
                default: begin
                    // status is read-only; unmapped addresses fault
                    msr_fault_next = 1'b1;
                end
            endcase
        end else if (msr_rd_en) begin
            case (msr_addr)
                `ADDR_FIX_CTR0, `ADDR_FIX_CTR1, `ADDR_FIX_CTR2, `ADDR_FIX_CTR3,
                `ADDR_FIX_CTRL, `ADDR_GLB_EN, `ADDR_GLB_STAT, `ADDR_GLB_CLR: begin
                    msr_fault_next = 1'b0;
                end
                default: begin
                    msr_fault_next = 1'b1;
                end
            endcase
        end
    end

    assign wr_ok = ~msr_fault_next;

    // read data, one cycle after the request
    always @* begin
        msr_rdata_next = `ZERO64;
        if (msr_rd_en & ~msr_wr_en) begin
            case (msr_addr)
                `ADDR_FIX_CTR0: msr_rdata_next = {{(64-CTR_WIDTH){1'b0}}, ctr_value[0]};
                `ADDR_FIX_CTR1: msr_rdata_next = {{(64-CTR_WIDTH){1'b0}}, ctr_value[1]};
                `ADDR_FIX_CTR2: msr_rdata_next = {{(64-CTR_WIDTH){1'b0}}, ctr_value[2]};
                `ADDR_FIX_CTR3: msr_rdata_next = {{(64-CTR_WIDTH){1'b0}}, ctr_value[3]};
                `ADDR_FIX_CTRL: msr_rdata_next = {48'h0000_0000_0000, fixed_counter_control_reg};
                `ADDR_GLB_EN: begin
                    msr_rdata_next[`ST_GP_LSB +: `NUM_GP]     = glb_gp_en_reg;
                    msr_rdata_next[`ST_FIX_LSB +: `NUM_FIXED] = glb_fix_en_reg;
                end
                `ADDR_GLB_STAT: msr_rdata_next = status_word;
                // the clear register is write-only and reads as zero
                default:        msr_rdata_next = `ZERO64;
            endcase
        end
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            msr_rdata_reg  <= `ZERO64;
            msr_done_reg   <= 1'b0;
            msr_fault_reg  <= 1'b0;
        end else begin
            msr_rdata_reg  <= msr_rdata_next;
            msr_done_reg   <= access;
            msr_fault_reg  <= access & msr_fault_next;
        end
    end

    // control and global enable registers
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fixed_counter_control_reg <= `CTL_RESET;
            glb_gp_en_reg             <= 2'h0;
            glb_fix_en_reg            <= 4'h0;
            gp_count_enable_reg       <= 2'h0;
            fixed_counter_width_reg   <= WIDTH_CODE;
        end else begin
            if (wr_ctl & wr_ok)
                fixed_counter_control_reg <= msr_wdata[`CTL_USED_W-1:0];        // [R1]
            if (wr_glb & wr_ok) begin
                glb_gp_en_reg  <= msr_wdata[`ST_GP_LSB +: `NUM_GP];
                glb_fix_en_reg <= msr_wdata[`ST_FIX_LSB +: `NUM_FIXED];          // [R6]
            end
            gp_count_enable_reg     <= glb_gp_en_reg;
            fixed_counter_width_reg <= WIDTH_CODE;                               // [R20]
        end
    end

    genvar g;
    generate
        for (g = 0; g < `NUM_FIXED; g = g + 1) begin : ctr
            fixed_counter_slice #(
                .CTR_WIDTH (CTR_WIDTH),
                .INC_WIDTH (INC_WIDTH)
            ) u_slice (
                .ref_clk      (ref_clk),
                .resetn       (resetn),
                .count_en     (count_en[g]),
                .inc          (inc_vec[INC_WIDTH*g +: INC_WIDTH]),
                .load_en      (load_en[g]),
                .load_value   (msr_wdata[CTR_WIDTH-1:0]),
                .value_reg    (ctr_value[g]),
                .overflow_reg (ctr_ovf[g])
            );
        end
    endgenerate

    // status flag sources; a set always beats a clear landing in the same cycle
    assign flag_set[`FLAG_FIX_LSB-1:0]               = gp_overflow;              // [R13]
    assign flag_set[`FLAG_FIX_LSB +: `NUM_FIXED]     = ctr_ovf;                  // [R13] [R19]
    assign flag_set[`FLAG_BUF_OVF]                   = |precise_record_done;     // [R14] [R16]
    assign flag_set[`FLAG_COND_CHG]                  = condition_change_event;   // [R15]

    assign flag_hw_clr[`FLAG_FIX_LSB-1:0]            = 2'h0;
    assign flag_hw_clr[`FLAG_FIX_LSB +: `NUM_FIXED]  = precise_record_done;      // [R16]
    assign flag_hw_clr[`FLAG_BUF_OVF]                = 1'b0;
    assign flag_hw_clr[`FLAG_COND_CHG]               = 1'b0;

    assign flag_sw_clr[`FLAG_FIX_LSB-1:0]            =
        {2{wr_clr & wr_ok}} & msr_wdata[`ST_GP_LSB +: `NUM_GP];                  // [R17]
    assign flag_sw_clr[`FLAG_FIX_LSB +: `NUM_FIXED]  =
        {4{wr_clr & wr_ok}} & msr_wdata[`ST_FIX_LSB +: `NUM_FIXED];              // [R17]
    assign flag_sw_clr[`FLAG_BUF_OVF]                = wr_clr & wr_ok & msr_wdata[`ST_BUF_OVF];
    assign flag_sw_clr[`FLAG_COND_CHG]               = wr_clr & wr_ok & msr_wdata[`ST_COND_CHG];

    generate
        for (g = 0; g < `NUM_FLAGS; g = g + 1) begin : flg
            status_flag u_flag (
                .ref_clk  (ref_clk),
                .resetn   (resetn),
                .set      (flag_set[g]),
                .hw_clear (flag_hw_clr[g]),
                .sw_clear (flag_sw_clr[g]),
                .flag_reg (flags[g])
            );
        end
    endgenerate

    assign status_word = {flags[`FLAG_COND_CHG], flags[`FLAG_BUF_OVF],           // [R14] [R15]
                          26'h000_0000, flags[`FLAG_FIX_LSB +: `NUM_FIXED],      // [R13]
                          30'h0000_0000, flags[`FLAG_FIX_LSB-1:0]};

    // interrupt pulse, aligned with the status flag becoming visible
    assign pmi_next = |(ctr_ovf & (precise_sampling_enable |                     // [R16]
                        {fixed_counter_control_reg[`CTL_GROUP_W*3 + `CTL_PMI],
                         fixed_counter_control_reg[`CTL_GROUP_W*2 + `CTL_PMI],
                         fixed_counter_control_reg[`CTL_GROUP_W*1 + `CTL_PMI],
                         fixed_counter_control_reg[`CTL_PMI]}));                 // [R5]

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            monitor_overflow_interrupt_reg <= 1'b0;
        else
            monitor_overflow_interrupt_reg <= pmi_next;                          // [R5]
    end
endmodule

// [verification/fixed_event_counter_control_props.sv]
// concurrent checks on the ports of the fixed event counter block
`timescale 1ns/1ps
`include "fixed_counter_defines.vh"
module fixed_event_counter_control_props #(
    parameter CTR_WIDTH = 48
) (
    input wire        ref_clk,
    input wire        resetn,
    input wire        msr_wr_en,
    input wire        msr_rd_en,
    input wire [31:0] msr_addr,
    input wire [63:0] msr_wdata,
    input wire [63:0] msr_rdata_reg,
    input wire        msr_done_reg,
    input wire        msr_fault_reg,
    input wire        halt_instruction_exec,
    input wire        monitor_wait_exec,
    input wire        halt_wake,
    input wire [1:0]  gp_count_enable_reg,
    input wire [7:0]  fixed_counter_width_reg,
    input wire        halted_reg
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence req_s;
        msr_wr_en || msr_rd_en;
    endsequence
    sequence ctrl_wr_s;
        msr_wr_en && msr_addr == `ADDR_FIX_CTRL;
    endsequence
    sequence en_wr_s;
        msr_wr_en && msr_addr == `ADDR_GLB_EN && (msr_wdata & ~`GLB_EN_MASK) == `ZERO64;
    endsequence
    sequence halt_s;
        halt_instruction_exec || monitor_wait_exec;
    endsequence

    reply_timing_a: assert property (req_s |=> msr_done_reg)
        else $error("no answer one cycle after a request");
    reply_cause_a: assert property (msr_done_reg |-> $past(msr_wr_en || msr_rd_en))
        else $error("answer without a request");
    fault_pair_a: assert property (msr_fault_reg |-> msr_done_reg)
        else $error("fault without answer");
    idle_rdata_a: assert property (!msr_done_reg |-> msr_rdata_reg == `ZERO64)
        else $error("read data not zero outside answer");
    reserved_fault_a: assert property (ctrl_wr_s |=>
        msr_fault_reg == ($past(msr_wdata[63:16]) != 48'h0))
        else $error("control write fault does not follow reserved bits");
    status_ro_a: assert property (msr_wr_en && msr_addr == `ADDR_GLB_STAT
        |=> msr_fault_reg)
        else $error("status write not refused");
    width_report_a: assert property (fixed_counter_width_reg == CTR_WIDTH)
        else $error("reported counter width wrong");
    enable_copy_a: assert property (en_wr_s |-> ##2
        gp_count_enable_reg == $past(msr_wdata[1:0], 2))
        else $error("global enable copy does not follow write");
    halt_entry_a: assert property (halt_s |=> halted_reg)
        else $error("halt not entered");
    halt_exit_a: assert property (halted_reg && halt_wake && !(halt_instruction_exec
        || monitor_wait_exec) |=> !halted_reg)
        else $error("halt not left on wake");
    halt_hold_a: assert property (halted_reg && !halt_wake |=> halted_reg)
        else $error("halt dropped without wake");
endmodule

// [verification/core_event_model.sv]
// processor core stand-in: privilege level and event bursts
`timescale 1ns/1ps
module core_event_model (
    input  wire       ref_clk,
    input  wire       resetn,
    input  wire       start,
    input  wire [7:0] len,
    input  wire       ring0,
    input  wire       therm,
    output reg        cpl_is_ring0,
    output reg        thermal_stop_clock,
    output wire       instr_retired,
    output wire       timestamp_tick,
    output wire       slot_available,
    output wire       busy
);
    reg [7:0] left_reg;
    assign busy = left_reg != 8'h00;
    // one pulse per whole instruction, never one per micro-op
    assign instr_retired  = busy;
    assign timestamp_tick = busy;
    assign slot_available = busy;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            left_reg <= 8'h00;
            cpl_is_ring0 <= 1'b1;
            thermal_stop_clock <= 1'b0;
        end else if (start) begin
            left_reg <= len;
            cpl_is_ring0 <= ring0;
            thermal_stop_clock <= therm;
        end else if (busy) begin
            left_reg <= left_reg - 8'h01;
        end
    end
endmodule

// [verification/fixed_event_counter_control_tb.sv]
// self-checking bench for the fixed event counter block
`timescale 1ns/1ps
`include "fixed_counter_defines.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module fixed_event_counter_control_tb;
    localparam CW = 16;
    localparam PW = 4;
    reg         ref_clk = 1'b0;
    reg         resetn = 1'b0;
    reg         msr_wr_en = 1'b0;
    reg         msr_rd_en = 1'b0;
    reg  [31:0] msr_addr = 32'h0;
    reg  [63:0] msr_wdata = 64'h0;
    reg  [3:0]  precise_sampling_enable = 4'h0;
    reg  [7:0]  pl = 8'h00;
    reg         ev_start = 1'b0;
    reg  [7:0]  ev_len = 8'h00;
    reg         ev_ring0 = 1'b1;
    reg         ev_therm = 1'b0;
    wire        halt_instruction_exec = pl[0];
    wire        monitor_wait_exec = pl[1];
    wire        halt_wake = pl[2];
    wire [1:0]  gp_overflow = pl[4:3];
    wire        condition_change_event = pl[5];
    wire [3:0]  precise_record_done = {3'b000, pl[6]};
    wire        cpl_is_ring0, instr_retired, thermal_stop_clock, timestamp_tick;
    wire        slot_available, ev_busy, msr_done_reg, msr_fault_reg, halted_reg;
    wire        monitor_overflow_interrupt_reg;
    wire [63:0] msr_rdata_reg;
    wire [1:0]  gp_count_enable_reg;
    wire [7:0]  fixed_counter_width_reg;
    reg  [63:0] rd, v0;
    reg         flt;
    integer     n_fail = 0, checks_done = 0, irq_n = 0, seed = 53964, i, k, n;

    fixed_event_counter_control #(.CTR_WIDTH(CW), .PIPE_WIDTH(PW)) dut (.ref_clk, .resetn,
        .msr_wr_en, .msr_rd_en, .msr_addr, .msr_wdata, .msr_rdata_reg, .msr_done_reg,
        .msr_fault_reg, .cpl_is_ring0, .instr_retired, .halt_instruction_exec,
        .monitor_wait_exec, .halt_wake, .thermal_stop_clock, .timestamp_tick, .slot_available,
        .gp_overflow, .precise_sampling_enable, .precise_record_done, .condition_change_event,
        .monitor_overflow_interrupt_reg, .gp_count_enable_reg, .fixed_counter_width_reg,
        .halted_reg);
    core_event_model evm (.ref_clk, .resetn, .start(ev_start), .len(ev_len), .ring0(ev_ring0),
        .therm(ev_therm), .cpl_is_ring0, .thermal_stop_clock, .instr_retired, .timestamp_tick,
        .slot_available, .busy(ev_busy));

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (monitor_overflow_interrupt_reg === 1'b1) irq_n <= irq_n + 1;

    function [63:0] exp_cnt(input [1:0] grp, input en, input r0, input [7:0] len);
        exp_cnt = (en && (r0 ? grp[0] : grp[1])) ? {56'h0, len} : 64'h0;
    endfunction
    function [31:0] amap(input integer j);
        amap = (j < 4) ? `ADDR_FIX_CTR0 + j : (j == 4) ? `ADDR_FIX_CTRL :
            (j == 5) ? `ADDR_GLB_EN : (j == 6) ? `ADDR_GLB_STAT : `ADDR_GLB_CLR;
    endfunction
    task stop_test;
        if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task acc(input w, input [31:0] a, input [63:0] d);
        @(posedge ref_clk);
        msr_wr_en <= w;
        msr_rd_en <= !w;
        msr_addr <= a;
        msr_wdata <= d;
        @(posedge ref_clk);
        msr_wr_en <= 1'b0;
        msr_rd_en <= 1'b0;
        #1;
        rd = msr_rdata_reg;
        flt = msr_fault_reg;
        `CHK("done", 1'b1, msr_done_reg)
    endtask
    task chk_rd(input [31:0] a, input [63:0] e);
        acc(1'b0, a, 64'h0);
        `CHK("rdata", e, rd)
    endtask
    task burst(input [7:0] len, input r0, input th);
        @(posedge ref_clk);
        ev_start <= 1'b1;
        ev_len <= len;
        ev_ring0 <= r0;
        ev_therm <= th;
        @(posedge ref_clk);
        ev_start <= 1'b0;
        repeat (len + 2) @(posedge ref_clk);
    endtask
    task pulse(input [7:0] m);
        @(posedge ref_clk);
        pl <= m;
        @(posedge ref_clk);
        pl <= 8'h00;
    endtask

    initial begin
        #400000;
        n_fail = n_fail + 1;
        stop_test;
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        for (i = 0; i < 8; i++) begin
            chk_rd(amap(i), 64'h0);
            `CHK("fault", 1'b0, flt)
        end
        acc(1'b0, 32'h0000_03ff, 64'h0);
        `CHK("unmapped", 1'b1, flt)
        acc(1'b1, `ADDR_GLB_STAT, 64'h1);
        `CHK("status ro", 1'b1, flt)
        repeat (4) begin
            v0 = $random(seed) & 16'hffff;
            acc(1'b1, `ADDR_FIX_CTRL, v0);
            chk_rd(`ADDR_FIX_CTRL, v0);
            acc(1'b1, `ADDR_FIX_CTRL, v0 | 64'h1_0000);
            `CHK("reserved", 1'b1, flt)
            chk_rd(`ADDR_FIX_CTRL, v0);
        end
        acc(1'b1, `ADDR_GLB_EN, `GLB_EN_MASK);
        chk_rd(`ADDR_GLB_EN, `GLB_EN_MASK);
        // every enable pair at both ring levels, global bit on and off
        for (k = 0; k < 16; k++) begin
            n = ($random(seed) & 31) + 1;
            acc(1'b1, `ADDR_FIX_CTRL, {62'h0, k[1:0]});
            acc(1'b1, `ADDR_GLB_EN, k[3] ? 64'h1_0000_0000 : 64'h0);
            acc(1'b1, `ADDR_FIX_CTR0, 64'h0);
            burst(n[7:0], k[2], 1'b0);
            chk_rd(`ADDR_FIX_CTR0, exp_cnt(k[1:0], k[3], k[2], n[7:0]));
        end
        acc(1'b1, `ADDR_FIX_CTRL, 64'h3300);
        acc(1'b1, `ADDR_GLB_EN, 64'hc_0000_0000);
        for (k = 0; k < 2; k++) begin
            n = ($random(seed) & 31) + 1;
            acc(1'b1, `ADDR_FIX_CTR2, 64'h0);
            acc(1'b1, `ADDR_FIX_CTR3, 64'h0);
            burst(n[7:0], $random(seed) & 1, k[0]);
            chk_rd(`ADDR_FIX_CTR2, k[0] ? 64'h0 : n);
            chk_rd(`ADDR_FIX_CTR3, n * PW);
        end
        // reads two cycles apart: counter one moves by two unless halted
        acc(1'b1, `ADDR_FIX_CTRL, 64'h30);
        acc(1'b1, `ADDR_GLB_EN, 64'h2_0000_0000);
        for (k = 0; k < 2; k++) begin
            pulse(8'h01 << k);
            acc(1'b0, `ADDR_FIX_CTR1, 64'h0);
            v0 = rd;
            chk_rd(`ADDR_FIX_CTR1, v0);
            pulse(8'h04);
            acc(1'b0, `ADDR_FIX_CTR1, 64'h0);
            v0 = rd;
            chk_rd(`ADDR_FIX_CTR1, v0 + 64'h2);
        end
        // overflow with no interrupt, with the interrupt bit, with precise sampling
        for (k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            precise_sampling_enable <= (k == 2) ? 4'h1 : 4'h0;
            acc(1'b1, `ADDR_FIX_CTRL, (k == 1) ? 64'hb : 64'h3);
            acc(1'b1, `ADDR_GLB_EN, 64'h1_0000_0000);
            acc(1'b1, `ADDR_FIX_CTR0, 64'hffff);
            v0 = irq_n;
            burst(8'h01, 1'b1, 1'b0);
            chk_rd(`ADDR_FIX_CTR0, 64'h0);
            chk_rd(`ADDR_GLB_STAT, 64'h1_0000_0000);
            `CHK("irq", (k != 0), irq_n - v0)
            pulse(8'h78);
            chk_rd(`ADDR_GLB_STAT, 64'hc000_0000_0000_0003);
            acc(1'b1, `ADDR_GLB_CLR, 64'h8000_0000_0000_0001);
            chk_rd(`ADDR_GLB_STAT, 64'h4000_0000_0000_0002);
            acc(1'b1, `ADDR_GLB_CLR, `GLB_CLR_MASK);
            chk_rd(`ADDR_GLB_STAT, 64'h0);
        end
        stop_test;
    end
endmodule

bind fixed_event_counter_control fixed_event_counter_control_props #(.CTR_WIDTH(CTR_WIDTH)) props (
    .ref_clk, .resetn, .msr_wr_en, .msr_rd_en, .msr_addr, .msr_wdata, .msr_rdata_reg,
    .msr_done_reg, .msr_fault_reg, .halt_instruction_exec, .monitor_wait_exec, .halt_wake,
    .gp_count_enable_reg, .fixed_counter_width_reg, .halted_reg);
